/* hw/bru_pkg.sv */
// package: operation codes, widths, bit positions and reset values of the byte rotate unit
package bru_pkg;
  localparam int unsigned DATA_W    = 8;
  localparam int unsigned MSB_POS   = 7;
  localparam int unsigned LSB_POS   = 0;
  localparam logic [7:0]  ACC_RESET = 8'h00;
  localparam logic        CARRY_RESET = 1'b0;
  localparam logic [7:0]  MEM_RESET = 8'h00;

  typedef enum logic [2:0] {
    ROTATE_LEFT_THROUGH_CARRY,
    ROTATE_LEFT_THROUGH_CARRY_TO_ACC,
    ROTATE_RIGHT_PLAIN,
    ROTATE_RIGHT_PLAIN_TO_ACC,
    ROTATE_RIGHT_THROUGH_CARRY,
    ROTATE_RIGHT_THROUGH_CARRY_TO_ACC
  } bru_op_type;
endpackage

/* hw/bru_rotator.sv */
// combinational single-bit rotator shared by all six operations
module bru_rotator (
  // operand
  input  wire logic [7:0] operand,
  input  wire logic       carry_in,
  // control
  input  wire logic       rot_right,
  input  wire logic       through_carry,
  // result
  output logic [7:0]      result,
  output logic            carry_out
);
  import bru_pkg::*;

  logic fill_bit;

  always_comb begin
    if (rot_right) begin
      fill_bit  = through_carry ? carry_in : operand[LSB_POS];
      result    = {fill_bit, operand[MSB_POS:1]};
      carry_out = through_carry ? operand[LSB_POS] : carry_in;
    end else begin
      fill_bit  = through_carry ? carry_in : operand[MSB_POS];
      result    = {operand[MSB_POS-1:0], fill_bit};
      carry_out = through_carry ? operand[MSB_POS] : carry_in;
    end
  end
endmodule // bru_rotator

/* hw/bru_byte_rotate_unit.sv */
// top: byte rotate unit with registered memory write-back, accumulator and carry
// Operation
// - left through carry: bits up, carry into bit 0, bit 7 to carry, write memory
// - left through carry to accumulator: same rotate, memory untouched
// - plain right rotate: bit 0 into bit 7, write memory, no flag change
// - plain right rotate to accumulator: memory and all flags unchanged
// - right through carry: carry into bit 7, bit 0 to carry, write memory
// - right through carry to accumulator: memory untouched, carry takes bit 0
module bru_byte_rotate_unit (
  // clock and reset
  input  wire logic                clk,
  input  wire logic                nrst,
  input  wire logic                clk_en,
  // decoder request
  input  wire logic                op_valid,
  input  wire bru_pkg::bru_op_type op_sel,
  input  wire logic [7:0]          op_addr,
  // data memory read side
  input  wire logic [7:0]          mem_rdata,
  // data memory write side
  output logic                     mem_we,
  output logic [7:0]               mem_waddr,
  output logic [7:0]               mem_wdata,
  // accumulator and carry
  output logic [7:0]               accumulator_reg,
  output logic                     carry_flag,
  output logic                     done
);
  import bru_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  // every output is a field of this struct, so each one leaves a flip-flop
  typedef struct packed {
    logic       mem_we;
    logic [7:0] mem_waddr;
    logic [7:0] mem_wdata;
    logic [7:0] acc;
    logic       carry;
    logic       done;
  } bru_state_type;

  bru_state_type state;
  bru_state_type next_state;

  logic [7:0] rot_result;
  logic       rot_carry;
  logic       rot_right;
  logic       through_carry;
  logic       to_acc;

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  // one decode feeds both the rotator and the choice of destination
  always_comb begin
    rot_right     = 1'b0;
    through_carry = 1'b0;
    to_acc        = 1'b0;
    case (op_sel)
      ROTATE_LEFT_THROUGH_CARRY: begin
        through_carry = 1'b1;
      end
      ROTATE_LEFT_THROUGH_CARRY_TO_ACC: begin
        through_carry = 1'b1;
        to_acc        = 1'b1;
      end
      ROTATE_RIGHT_PLAIN: begin
        rot_right = 1'b1;
      end
      ROTATE_RIGHT_PLAIN_TO_ACC: begin
        rot_right = 1'b1;
        to_acc    = 1'b1;
      end
      ROTATE_RIGHT_THROUGH_CARRY: begin
        rot_right     = 1'b1;
        through_carry = 1'b1;
      end
      ROTATE_RIGHT_THROUGH_CARRY_TO_ACC: begin
        rot_right     = 1'b1;
        through_carry = 1'b1;
        to_acc        = 1'b1;
      end
      default: begin
        rot_right = 1'b0;
      end
    endcase
  end

  // the rotator reads the registered carry, so back-to-back operations chain
  // through the carry produced one cycle earlier
  bru_rotator u_rot (
    .operand       (mem_rdata),
    .carry_in      (state.carry),
    .rot_right     (rot_right),
    .through_carry (through_carry),
    .result        (rot_result),
    .carry_out     (rot_carry)
  );

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  // the write strobe and done are pulses of one enabled cycle; unknown codes are ignored
  // so a bad decode never corrupts memory or carry
  always_comb begin
    next_state        = state;
    next_state.mem_we = 1'b0;
    next_state.done   = 1'b0;
    if (op_valid && (op_sel <= ROTATE_RIGHT_THROUGH_CARRY_TO_ACC)) begin
      next_state.done  = 1'b1;
      next_state.carry = rot_carry;
      if (to_acc) begin
        next_state.acc = rot_result;
      end else begin
        next_state.mem_we    = 1'b1;
        next_state.mem_waddr = op_addr;
        next_state.mem_wdata = rot_result;
      end
    end
  end

  // a low clock enable freezes every field, pulses included, so a stalled
  // core still sees done and the write strobe until it moves on again
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state.mem_we    <= 1'b0;
      state.mem_waddr <= MEM_RESET;
      state.mem_wdata <= MEM_RESET;
      state.acc       <= ACC_RESET;
      state.carry     <= CARRY_RESET;
      state.done      <= 1'b0;
    end else if (clk_en) begin
      state <= next_state;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign mem_we          = state.mem_we;
  assign mem_waddr       = state.mem_waddr;
  assign mem_wdata       = state.mem_wdata;
  assign accumulator_reg = state.acc;
  assign carry_flag      = state.carry;
  assign done            = state.done;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  // $past in a consequent sees the operand and carry of the taking edge,
  // which is what every rotate consumes
  a_rlc_mem: assert property (@(posedge clk) disable iff (!nrst)
    (clk_en && op_valid && op_sel == ROTATE_LEFT_THROUGH_CARRY) |=>
      (mem_we && mem_wdata == {$past(mem_rdata[6:0]), $past(carry_flag)} && carry_flag == $past(mem_rdata[7])))
    else $error("left through carry result wrong");

  a_rotate_left_through_carry_to_acc_acc: assert property (@(posedge clk) disable iff (!nrst)
    (clk_en && op_valid && op_sel == ROTATE_LEFT_THROUGH_CARRY_TO_ACC) |=>
      (!mem_we && accumulator_reg == {$past(mem_rdata[6:0]), $past(carry_flag)} && carry_flag == $past(mem_rdata[7])))
    else $error("left through carry to accumulator wrong");

  a_rr_mem: assert property (@(posedge clk) disable iff (!nrst)
    (clk_en && op_valid && op_sel == ROTATE_RIGHT_PLAIN) |=>
      (mem_we && mem_wdata == {$past(mem_rdata[0]), $past(mem_rdata[7:1])} && $stable(carry_flag)))
    else $error("plain right rotate wrong");

  a_rra_acc: assert property (@(posedge clk) disable iff (!nrst)
    (clk_en && op_valid && op_sel == ROTATE_RIGHT_PLAIN_TO_ACC) |=>
      (!mem_we && accumulator_reg == {$past(mem_rdata[0]), $past(mem_rdata[7:1])} && $stable(carry_flag)))
    else $error("plain right rotate to accumulator wrong");

  a_rrc_mem: assert property (@(posedge clk) disable iff (!nrst)
    (clk_en && op_valid && op_sel == ROTATE_RIGHT_THROUGH_CARRY) |=>
      (mem_we && mem_wdata == {$past(carry_flag), $past(mem_rdata[7:1])} && carry_flag == $past(mem_rdata[0])))
    else $error("right through carry result wrong");

  a_rotate_right_through_carry_to_acc_acc: assert property (@(posedge clk) disable iff (!nrst)
    (clk_en && op_valid && op_sel == ROTATE_RIGHT_THROUGH_CARRY_TO_ACC) |=>
      (!mem_we && accumulator_reg == {$past(carry_flag), $past(mem_rdata[7:1])} && carry_flag == $past(mem_rdata[0])))
    else $error("right through carry to accumulator wrong");

  a_one_cycle: assert property (@(posedge clk) disable iff (!nrst)
    (clk_en && op_valid && op_sel <= ROTATE_RIGHT_THROUGH_CARRY_TO_ACC) |=> done)
    else $error("operation did not finish in one cycle");

  a_acc_hold: assert property (@(posedge clk) disable iff (!nrst)
    (mem_we) |-> $stable(accumulator_reg))
    else $error("accumulator changed on a memory destination");

  a_idle_hold: assert property (@(posedge clk) disable iff (!nrst)
    (clk_en && !op_valid) |=> (!done && !mem_we && $stable(carry_flag) && $stable(accumulator_reg)))
    else $error("state changed without an operation");

  a_frozen_hold: assert property (@(posedge clk) disable iff (!nrst)
    (!clk_en) |=>
      ($stable(done) && $stable(mem_we) && $stable(mem_waddr) && $stable(mem_wdata) &&
       $stable(carry_flag) && $stable(accumulator_reg)))
    else $error("state moved while the clock enable was low");

  a_bad_code: assert property (@(posedge clk) disable iff (!nrst)
    (clk_en && op_valid && op_sel > ROTATE_RIGHT_THROUGH_CARRY_TO_ACC) |=>
      (!done && !mem_we && $stable(carry_flag) && $stable(accumulator_reg)))
    else $error("unused operation code changed state");

  a_write_addr: assert property (@(posedge clk) disable iff (!nrst)
    (clk_en && op_valid &&
     op_sel inside {ROTATE_LEFT_THROUGH_CARRY, ROTATE_RIGHT_PLAIN, ROTATE_RIGHT_THROUGH_CARRY}) |=>
      (mem_waddr == $past(op_addr)))
    else $error("write-back went to the wrong address");

  a_done_with_we: assert property (@(posedge clk) disable iff (!nrst)
    (mem_we) |-> done)
    else $error("write strobe without a finished operation");

  a_acc_dest_only: assert property (@(posedge clk) disable iff (!nrst)
    (!(clk_en && op_valid && to_acc)) |=> $stable(accumulator_reg))
    else $error("accumulator changed outside an accumulator operation");

  a_acc_no_write: assert property (@(posedge clk) disable iff (!nrst)
    (clk_en && op_valid && to_acc) |=> (!mem_we && $stable(mem_waddr) && $stable(mem_wdata)))
    else $error("accumulator operation touched the memory write side");
endmodule // bru_byte_rotate_unit

/* verification/bru_mem_model.sv */
// data memory model that feeds operands to the rotate unit and takes its write-backs
module bru_mem_model (
  // clock
  input  wire logic       clk,
  // read side
  input  wire logic [7:0] rd_addr,
  output logic [7:0]      rd_data,
  // write side
  input  wire logic       we,
  input  wire logic [7:0] waddr,
  input  wire logic [7:0] wdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [256];
  // read is combinational: the operand has to be ready in the request cycle
  assign rd_data = mem[rd_addr];
  always @(posedge clk) if (we) mem[waddr] <= wdata;
endmodule // bru_mem_model

/* verification/bru_byte_rotate_unit_tb.sv */
// self-checking testbench of the byte rotate unit
module bru_byte_rotate_unit_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import bru_pkg::*;
  logic       clk = 1'b0, nrst = 1'b0, clk_en = 1'b1, op_valid = 1'b0;
  bru_op_type op_sel = ROTATE_LEFT_THROUGH_CARRY;
  logic [7:0] op_addr = 8'h00;
  logic [7:0] mem_rdata, mem_waddr, mem_wdata, accumulator_reg;
  logic       mem_we, carry_flag, done, c_exp;
  int         n_mismatch = 0, tests_run = 0;

  bru_byte_rotate_unit bru_byte_rotate_unit_i (.clk(clk), .nrst(nrst), .clk_en(clk_en), .op_valid(op_valid),
    .op_sel(op_sel), .op_addr(op_addr), .mem_rdata(mem_rdata), .mem_we(mem_we), .mem_waddr(mem_waddr),
    .mem_wdata(mem_wdata), .accumulator_reg(accumulator_reg), .carry_flag(carry_flag), .done(done));
  bru_mem_model bru_mem_model_i (.clk(clk), .rd_addr(op_addr), .rd_data(mem_rdata), .we(mem_we),
    .waddr(mem_waddr), .wdata(mem_wdata));

  always #4 clk = ~clk;

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic chk(input logic [8:0] got, input logic [8:0] exp, input string what);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // requests stay up so calls can run back to back; idle() drops the strobe
  task automatic do_op(input bru_op_type op, input logic [7:0] addr, input logic [7:0] val);
    logic       to_acc;
    logic       c_new;
    logic [7:0] res;
    logic [7:0] acc_old;
    to_acc = op inside {ROTATE_LEFT_THROUGH_CARRY_TO_ACC, ROTATE_RIGHT_PLAIN_TO_ACC, ROTATE_RIGHT_THROUGH_CARRY_TO_ACC};
    c_new = c_exp;
    case (op)
      ROTATE_LEFT_THROUGH_CARRY, ROTATE_LEFT_THROUGH_CARRY_TO_ACC: {c_new, res} = {val, c_exp};
      ROTATE_RIGHT_PLAIN, ROTATE_RIGHT_PLAIN_TO_ACC: res = {val[0], val[7:1]};
      default: {res, c_new} = {c_exp, val};
    endcase
    bru_mem_model_i.mem[addr] = val;
    acc_old = accumulator_reg;
    op_valid = 1'b1;
    op_sel = op;
    op_addr = addr;
    @(negedge clk);
    chk({7'h00, done, mem_we}, {7'h00, 1'b1, ~to_acc}, "strobes");
    chk({carry_flag, to_acc ? accumulator_reg : mem_wdata}, {c_new, res}, "result");
    chk({1'b0, to_acc ? bru_mem_model_i.mem[addr] : accumulator_reg}, {1'b0, to_acc ? val : acc_old}, "kept");
    if (!to_acc) chk({1'b0, mem_waddr}, {1'b0, addr}, "address");
    c_exp = c_new;
  endtask

  task automatic idle();
    op_valid = 1'b0;
    @(negedge clk);
    chk({7'h00, done, mem_we}, 9'h000, "pulse width");
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_left();
    do_op(ROTATE_LEFT_THROUGH_CARRY, 8'h10, 8'h81);
    do_op(ROTATE_LEFT_THROUGH_CARRY_TO_ACC, 8'h11, 8'h40);
    idle();
    $display("test left done");
  endtask

  task automatic t_right_plain();
    do_op(ROTATE_LEFT_THROUGH_CARRY, 8'h12, 8'h80);
    do_op(ROTATE_RIGHT_PLAIN, 8'h13, 8'h01);
    do_op(ROTATE_RIGHT_PLAIN_TO_ACC, 8'h14, 8'h02);
    idle();
    $display("test right plain done");
  endtask

  task automatic t_right_carry();
    do_op(ROTATE_RIGHT_THROUGH_CARRY, 8'h15, 8'h03);
    do_op(ROTATE_RIGHT_THROUGH_CARRY_TO_ACC, 8'h16, 8'hfe);
    do_op(ROTATE_RIGHT_THROUGH_CARRY, 8'h17, 8'h00);
    idle();
    $display("test right carry done");
  endtask

  // unused code 6 and a frozen clock enable must leave everything alone
  task automatic t_refused();
    bru_mem_model_i.mem[8'h20] = 8'hff;
    do_op(ROTATE_RIGHT_PLAIN, 8'h21, 8'h01);
    clk_en = 1'b0;
    op_sel = ROTATE_LEFT_THROUGH_CARRY;
    op_addr = 8'h20;
    @(negedge clk);
    chk({done, mem_we, carry_flag, 6'h00}, {2'b11, c_exp, 6'h00}, "frozen");
    clk_en = 1'b1;
    op_sel = bru_op_type'(3'h6);
    @(negedge clk);
    chk({done, mem_we, carry_flag, 6'h00}, {2'b00, c_exp, 6'h00}, "code 6");
    op_valid = 1'b0;
    $display("test refused done");
  endtask

  // a mid-run reset clears at once, and a request right after release is taken
  task automatic t_reset();
    do_op(ROTATE_LEFT_THROUGH_CARRY_TO_ACC, 8'h22, 8'hc3);
    op_valid = 1'b0;
    nrst = 1'b0;
    #1;
    chk({carry_flag, accumulator_reg}, {CARRY_RESET, ACC_RESET}, "async reset");
    repeat (2) @(negedge clk);
    nrst = 1'b1;
    c_exp = CARRY_RESET;
    do_op(ROTATE_RIGHT_THROUGH_CARRY, 8'h23, 8'h01);
    idle();
    $display("test reset done");
  endtask

  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // ----------------------------------------
  // main sequence and watchdog
  // ----------------------------------------
  initial begin
    c_exp = CARRY_RESET;
    repeat (10) @(negedge clk);
    nrst = 1'b1;
    @(negedge clk);
    chk({carry_flag, accumulator_reg}, {CARRY_RESET, ACC_RESET}, "reset");
    t_left();
    t_right_plain();
    t_right_carry();
    t_refused();
    t_reset();
    end_sim();
  end

  initial begin
    #5000;
    n_mismatch++;
    end_sim();
  end
endmodule // bru_byte_rotate_unit_tb
